// file: core/oodt_top.sv
`timescale 1ns/100ps
module oodt_top #(
	parameter int unsigned tick_div = oodt_pkg::tick_cycles,
	parameter logic [15:0] on_fixed = 16'h0064,
	parameter logic [15:0] off_fixed = 16'h0064
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_power_up,
	input wire logic i_on_trg,
	input wire logic i_off_trg,
	input wire logic i_off_clear,
	input wire logic i_on_retain,
	input wire logic i_off_retain,
	input wire logic i_on_use_ext,
	input wire logic i_off_use_ext,
	input wire logic [15:0] i_on_ext_preset,
	input wire logic [15:0] i_off_ext_preset,
	input wire logic [1:0] i_on_base,
	input wire logic [1:0] i_off_base,
	output logic o_on_q,
	output logic o_off_q,
	output logic [15:0] o_on_elapsed_time,
	output logic [15:0] o_off_elapsed_time,
	output logic [15:0] o_on_ref,
	output logic [15:0] o_off_ref
);
	typedef struct packed {
		logic [1:0] on_sync;
		logic on_trg;
		logic on_trg_d;
		logic [1:0] off_sync;
		logic off_trg;
		logic off_trg_d;
		logic [1:0] clr_sync;
		logic clr;
		logic [1:0] pwr_sync;
		logic pwr;
		logic on_run;
		logic on_q;
		logic [15:0] on_elapsed;
		logic off_run;
		logic off_q;
		logic [15:0] off_elapsed;
	} oodt_top_st_t;
	oodt_top_st_t st, next_st;
	logic tick;
	logic [15:0] on_preset;
	logic [15:0] off_preset;
	function automatic logic [15:0] step(input logic [15:0] t,
		input logic [15:0] lim, input logic en);
		step = t;
		if (en && t < lim) begin
			step = t + 16'h0001;
		end
	endfunction
	oodt_tick #(
		.divide(tick_div)
	) u_tick (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.o_tick(tick)
	);
	oodt_ref u_on_ref (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_base(i_on_base),
		.i_elapsed(st.on_elapsed),
		.o_ref(o_on_ref)
	);
	oodt_ref u_off_ref (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_base(i_off_base),
		.i_elapsed(st.off_elapsed),
		.o_ref(o_off_ref)
	);
	always_comb begin
		on_preset = i_on_use_ext ? i_on_ext_preset : on_fixed;
		off_preset = i_off_use_ext ? i_off_ext_preset : off_fixed;
	end
	always_comb begin
		next_st = st;
		next_st.on_sync = {st.on_sync[0], i_on_trg};
		next_st.on_trg = st.on_sync[1];
		next_st.on_trg_d = st.on_trg;
		next_st.off_sync = {st.off_sync[0], i_off_trg};
		next_st.off_trg = st.off_sync[1];
		next_st.off_trg_d = st.off_trg;
		next_st.clr_sync = {st.clr_sync[0], i_off_clear};
		next_st.clr = st.clr_sync[1];
		next_st.pwr_sync = {st.pwr_sync[0], i_power_up};
		next_st.pwr = st.pwr_sync[1];
		// on-delay timer
		if (!st.on_trg) begin
			next_st.on_q = 1'b0;
			next_st.on_run = 1'b0;
			next_st.on_elapsed = 16'h0000;
		end else if (!st.on_trg_d) begin
			next_st.on_run = 1'b1;
			next_st.on_elapsed = 16'h0000;
		end else if (st.on_run) begin
			next_st.on_elapsed = step(st.on_elapsed, on_preset, tick);
			if (next_st.on_elapsed >= on_preset) begin
				next_st.on_q = 1'b1;
				next_st.on_run = 1'b0;
			end
		end
		// off-delay timer
		if (st.clr) begin
			next_st.off_q = 1'b0;
			next_st.off_run = 1'b0;
			next_st.off_elapsed = 16'h0000;
		end else if (st.off_trg) begin
			if (!st.off_trg_d) begin
				next_st.off_q = 1'b1;
			end
			next_st.off_run = 1'b0;
			next_st.off_elapsed = 16'h0000;
		end else if (st.off_trg_d) begin
			next_st.off_run = st.off_q;
			next_st.off_elapsed = 16'h0000;
		end else if (st.off_run) begin
			next_st.off_elapsed = step(st.off_elapsed, off_preset, tick);
			if (next_st.off_elapsed == off_preset) begin
				next_st.off_q = 1'b0;
				next_st.off_run = 1'b0;
			end
		end
		// power-up: clear unless retention on
		if (st.pwr) begin
			if (!i_on_retain) begin
				next_st.on_q = 1'b0;
				next_st.on_run = 1'b0;
				next_st.on_elapsed = 16'h0000;
			end else begin
				next_st.on_q = st.on_q;
				next_st.on_run = st.on_run;
				next_st.on_elapsed = st.on_elapsed;
			end
			if (!i_off_retain) begin
				next_st.off_q = 1'b0;
				next_st.off_run = 1'b0;
				next_st.off_elapsed = 16'h0000;
			end else begin
				next_st.off_q = st.off_q;
				next_st.off_run = st.off_run;
				next_st.off_elapsed = st.off_elapsed;
			end
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign o_on_q = st.on_q;
	assign o_off_q = st.off_q;
	assign o_on_elapsed_time = st.on_elapsed;
	assign o_off_elapsed_time = st.off_elapsed;
endmodule

// file: core/oodt_pkg.sv
// Function
// - on-delay trigger rising edge starts elapsed time from zero
// - on-delay output goes 1 when elapsed reaches preset with trigger held
// - on-delay trigger falling early discards elapsed time
// - on-delay output forced 0 whenever trigger is 0, except during power-up with retention on
// - off-delay trigger rising edge sets output at once
// - off-delay trigger falling edge restarts elapsed time, output stays 1
// - off-delay output goes 0 when elapsed equals preset
// - further trigger pulse while running restarts elapsed time
// - off-delay clear zeroes elapsed time and output, beats trigger
// - with retention on, state and elapsed time survive power loss
// - retention defaults off; off means state cleared at power-up
// - reference value is a*60+b, or a*100+b for third base (sc)
// - preset is fixed constant or live external value, by configuration
package oodt_pkg;
	localparam int unsigned time_w = 16;
	localparam int unsigned field_w = 8;
	localparam int unsigned ref_w = 16;
	localparam int unsigned clk_hz = 40000000;
	localparam int unsigned tick_ms = 10;
	localparam int unsigned tick_cycles = clk_hz / 1000 * tick_ms;
	localparam logic [time_w-1:0] elapsed_reset = 16'h0000;
	localparam logic [ref_w-1:0] mult_sixty = 16'h003c;
	localparam logic [ref_w-1:0] mult_hundred = 16'h0064;
	typedef enum logic [1:0] {
		oodt_base_hm = 2'b00,
		oodt_base_ms = 2'b01,
		oodt_base_sc = 2'b10
	} oodt_base_t;
	typedef enum logic [1:0] {
		oodt_idle = 2'b00,
		oodt_run = 2'b01,
		oodt_done = 2'b10
	} oodt_state_t;
endpackage

// file: core/oodt_tick.sv
`timescale 1ns/100ps
module oodt_tick #(
	parameter int unsigned divide = oodt_pkg::tick_cycles
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	output logic o_tick
);
	if (divide < 2) begin
		$error("divide too small");
	end
	typedef struct packed {
		logic [31:0] count;
		logic tick;
	} oodt_tick_st_t;
	oodt_tick_st_t st, next_st;
	always_comb begin
		next_st = st;
		next_st.tick = 1'b0;
		if (st.count == divide - 1) begin
			next_st.count = 32'h00000000;
			next_st.tick = 1'b1;
		end else begin
			next_st.count = st.count + 32'h00000001;
		end
	end
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign o_tick = st.tick;
endmodule

// file: core/oodt_ref.sv
`timescale 1ns/100ps
module oodt_ref (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic [1:0] i_base,
	input wire logic [15:0] i_elapsed,
	output logic [15:0] o_ref
);
	typedef struct packed {
		logic [15:0] value;
	} oodt_ref_st_t;
	oodt_ref_st_t st, next_st;
	function automatic logic [15:0] ref_of(input logic [1:0] base,
		input logic [15:0] t);
		logic [31:0] prod;
		prod = 32'h00000000;
		if (base == oodt_pkg::oodt_base_sc) begin
			prod = {24'h000000, t[15:8]} * {16'h0000, oodt_pkg::mult_hundred};
		end else begin
			prod = {24'h000000, t[15:8]} * {16'h0000, oodt_pkg::mult_sixty};
		end
		ref_of = prod[15:0] + {8'h00, t[7:0]};
	endfunction
	always_comb begin
		next_st.value = ref_of(i_base, i_elapsed);
	end
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign o_ref = st.value;
endmodule

// file: testbench/oodt_properties.sv
`timescale 1ns/100ps
module oodt_properties #(
	parameter logic [15:0] on_fixed = 16'h0064,
	parameter logic [15:0] off_fixed = 16'h0064
) (
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_power_up,
	input wire logic i_on_trg,
	input wire logic i_off_trg,
	input wire logic i_off_clear,
	input wire logic i_on_use_ext,
	input wire logic i_off_use_ext,
	input wire logic [15:0] i_on_ext_preset,
	input wire logic [15:0] i_off_ext_preset,
	input wire logic [1:0] i_on_base,
	input wire logic [1:0] i_off_base,
	input wire logic o_on_q,
	input wire logic o_off_q,
	input wire logic [15:0] o_on_elapsed_time,
	input wire logic [15:0] o_off_elapsed_time,
	input wire logic [15:0] o_on_ref,
	input wire logic [15:0] o_off_ref
);
	logic [7:0] quiet;
	logic [15:0] onp;
	logic [15:0] offp;
	assign onp = i_on_use_ext ? i_on_ext_preset : on_fixed;
	assign offp = i_off_use_ext ? i_off_ext_preset : off_fixed;
	function automatic logic [15:0] rv(logic [15:0] t, logic [1:0] b);
		return (b == 2'h2 ? 16'h0064 : 16'h003c) * t[15:8] + t[7:0];
	endfunction
	always_ff @(posedge i_mclk) begin
		quiet <= {quiet[6:0], i_off_clear | i_power_up | i_reset};
	end
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	on_low_a: assert property (!i_on_trg [*8] |->
		!o_on_q && o_on_elapsed_time == 16'h0000) else $error("on idle");
	on_set_a: assert property ($rose(o_on_q) |->
		o_on_elapsed_time == onp) else $error("on set early");
	on_sat_a: assert property (o_on_elapsed_time <= onp)
		else $error("on count past preset");
	off_set_a: assert property ($rose(i_off_trg) && !i_off_clear
		&& quiet == 8'h00 |-> ##[1:6] o_off_q) else $error("off not set");
	off_hold_a: assert property (i_off_trg [*6] ##0 quiet == 8'h00
		|-> o_off_q) else $error("off dropped");
	off_done_a: assert property ($fell(o_off_q) && quiet == 8'h00
		|-> o_off_elapsed_time == offp) else $error("off early");
	clear_zero_a: assert property (i_off_clear [*6] |-> !o_off_q
		&& o_off_elapsed_time == 16'h0000) else $error("clear");
	on_ref_a: assert property ($stable(i_on_base) |=> o_on_ref ==
		rv($past(o_on_elapsed_time), $past(i_on_base))) else $error("ref");
	off_ref_a: assert property ($stable(i_off_base) |=> o_off_ref ==
		rv($past(o_off_elapsed_time), $past(i_off_base))) else $error("ref");
	cover property ($rose(o_on_q));
	cover property ($fell(o_off_q) && quiet == 8'h00);
	cover property (i_off_clear && i_off_trg);
endmodule

// file: testbench/tb.sv
`timescale 1ns/100ps
module tb;
	localparam logic [15:0] onf = 16'h0006;
	localparam logic [15:0] offf = 16'h0005;
	logic i_mclk, i_reset, i_power_up, i_on_trg, i_off_trg, i_off_clear;
	logic i_on_retain, i_off_retain, i_on_use_ext, i_off_use_ext;
	logic [15:0] i_on_ext_preset, i_off_ext_preset;
	logic [1:0] i_on_base, i_off_base;
	logic o_on_q, o_off_q;
	logic [15:0] o_on_elapsed_time, o_off_elapsed_time, o_on_ref, o_off_ref;
	logic [15:0] e;
	int error_cnt, num_checks, n;
	oodt_top #(.tick_div(4), .on_fixed(onf), .off_fixed(offf))
		oodt_top_inst (.*);
	initial begin
		i_mclk = 1'b0;
		forever #12.5 i_mclk = ~i_mclk;
	end
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(int k);
		repeat (k) @(negedge i_mclk);
	endtask
	task automatic wait_for(input bit off, input logic v);
		n = 0;
		while ((off ? o_off_q : o_on_q) !== v) begin
			cyc(1);
			n++;
			if (n > 2000) begin
				error_cnt++;
				conclude();
			end
		end
	endtask
	function automatic logic [15:0] rv(logic [15:0] t, logic [1:0] b);
		return (b == 2'h2 ? 16'h0064 : 16'h003c) * t[15:8] + t[7:0];
	endfunction
	initial begin
		{i_reset, i_power_up, i_on_trg, i_off_trg, i_off_clear} = 5'h10;
		{i_on_retain, i_off_retain, i_on_use_ext, i_off_use_ext} = 4'h0;
		{i_on_ext_preset, i_off_ext_preset} = 32'h0;
		{i_on_base, i_off_base} = 4'h0;
		void'($urandom(32'heb64));
		cyc(3);
		i_reset = 1'b0;
		check("reset", 16'(o_on_q | o_off_q), 16'h0000);
		for (int i = 0; i < 6; i++) begin
			i_on_use_ext = 1'(i > 0);
			i_on_ext_preset = 16'($urandom_range(9, 2));
			i_on_base = 2'(i % 3);
			i_off_base = 2'(2 - i % 3);
			cyc(2);
			i_on_trg = 1'b1;
			wait_for(1'b0, 1'b1);
			e = i_on_use_ext ? i_on_ext_preset : onf;
			check("on_time", o_on_elapsed_time, e);
			check("on_wait", 16'(n > 4 * (e - 1) && n <= 4 * e + 8), 1);
			cyc(2);
			check("on_ref", o_on_ref, rv(e, i_on_base));
			i_on_trg = 1'b0;
			cyc(8);
			check("on_q", 16'(o_on_q), 16'h0000);
		end
		i_on_use_ext = 1'b1;
		i_on_ext_preset = 16'h0105;
		i_on_base = 2'h2;
		cyc(2);
		i_on_trg = 1'b1;
		wait_for(1'b0, 1'b1);
		cyc(2);
		check("on_ref_sc", o_on_ref, rv(i_on_ext_preset, i_on_base));
		i_on_base = 2'h1;
		cyc(2);
		check("on_ref_ms", o_on_ref, rv(i_on_ext_preset, i_on_base));
		i_on_trg = 1'b0;
		cyc(8);
		i_on_use_ext = 1'b0;
		i_on_trg = 1'b1;
		cyc(10);
		i_on_trg = 1'b0;
		cyc(1);
		i_on_trg = 1'b1;
		cyc(6);
		check("on_restart", 16'(o_on_elapsed_time < 2), 1);
		cyc(6);
		e = o_on_elapsed_time;
		i_on_retain = 1'b1;
		i_power_up = 1'b1;
		cyc(4);
		check("retained", 16'(o_on_elapsed_time >= e && e > 0), 1);
		i_on_retain = 1'b0;
		cyc(4);
		check("not_retained", o_on_elapsed_time, 16'h0000);
		{i_power_up, i_on_trg} = 2'b00;
		for (int j = 0; j < 2; j++) begin
			i_off_use_ext = 1'(j);
			i_off_ext_preset = 16'($urandom_range(8, 5));
			e = i_off_use_ext ? i_off_ext_preset : offf;
			cyc(10);
			i_off_trg = 1'b1;
			cyc(6);
			check("off_set", 16'(o_off_q), 16'h0001);
			i_off_trg = 1'b0;
			cyc(12);
			check("off_held", 16'(o_off_q), 16'h0001);
			i_off_trg = 1'b1;
			cyc(2);
			i_off_trg = 1'b0;
			wait_for(1'b1, 1'b0);
			check("off_ext", 16'(n > 4 * (e - 1)), 1);
			check("off_time", o_off_elapsed_time, e);
			cyc(2);
			check("off_ref", o_off_ref, rv(e, i_off_base));
		end
		{i_off_trg, i_off_clear} = 2'b11;
		cyc(6);
		check("clear", {o_off_elapsed_time[14:0], o_off_q}, 16'h0000);
		{i_off_trg, i_off_clear} = 2'b00;
		cyc(4);
		conclude();
	end
endmodule
bind oodt_top oodt_properties #(.on_fixed(on_fixed), .off_fixed(off_fixed))
	oodt_properties_inst (.*);
